/* File: src/ipmc_cfg.svh */
`ifndef IPMC_CFG_SVH
`define IPMC_CFG_SVH
// register offsets on the plain register port
`define IPMC_ADDR_ENABLE    4'h0
`define IPMC_ADDR_PRIORITY  4'h1
`define IPMC_ADDR_POWER     4'h2
`define IPMC_ADDR_FLAGS     4'h3
`define IPMC_ADDR_IRQ_STAT  4'h4
`define IPMC_ADDR_IRQ_MASK  4'h5
`define IPMC_ADDR_STATUS    4'h6
`define IPMC_ADDR_RETI      4'h7
// field positions
`define IPMC_EN_GLOBAL_BIT  7
`define IPMC_PWR_IDLE_BIT   0
`define IPMC_PWR_PD_BIT     1
// reset values
`define IPMC_ENABLE_RST     8'h00
`define IPMC_PRIORITY_RST   8'h00
`define IPMC_POWER_RST      8'h00
// vectors
`define IPMC_VEC_RESET      16'h0000
`define IPMC_VEC_EXT0       16'h0003
`define IPMC_VEC_TMR0       16'h000B
`define IPMC_VEC_EXT1       16'h0013
`define IPMC_VEC_TMR1       16'h001B
`define IPMC_VEC_SERIAL     16'h0023
// idle-exit-by-reset window, machine cycles
`define IPMC_RST_WIN_MC     2
`endif

/* File: src/ipmc_pkg.sv */
package ipmc_pkg;
	typedef enum logic [1:0] {
		IPMC_RUN  = 2'b00,
		IPMC_IDLE = 2'b01,
		IPMC_PDWN = 2'b10
	} ipmc_pwr_e;
	typedef struct packed {
		logic       valid;
		logic [2:0] src;
		logic       high;
		logic [15:0] vector;
	} ipmc_req_s;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ipmc_bus_s;
endpackage

/* File: src/ipmc_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - five sources: ext0, timer0, ext1, timer1, serial; each with two levels
// - low-level service can only be preempted by a high-level request
// - high-level service cannot be preempted by anything
// - simultaneous requests: higher level serviced first
// - equal level: ext0, timer0, ext1, timer1, serial polling order
// - vectors 0003/000B/0013/001B/0023; serial is receive or transmit; reset 0000
// - software write enters idle: cpu clock gated, peripherals keep running
// - internal ram and enable, priority and power registers held during idle; event status and mask stay writable
// - idle ends on any enabled interrupt or hardware reset
// - reset ending idle: two machine cycles, ram writes blocked, ports not
// - power control bit 0 selects idle, bit 1 selects power-down
// - power-down stops oscillator, keeps contents, ended only by reset
// - reset that ends power-down restarts the oscillator
// - reset ending power-down reloads registers, leaves internal ram alone
// - enable register with global bit, priority register, per source
`include "ipmc_cfg.svh"
module ipmc_ctrl #(
	parameter int NSRC = 5
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               mc_en,
	input  wire ipmc_pkg::ipmc_bus_s bus,
	output logic [7:0]              rdata,
	input  wire logic               ext_request_pin_0,
	input  wire logic               ext_request_pin_1,
	input  wire logic               timer0_overflow_flag,
	input  wire logic               timer1_overflow_flag,
	input  wire logic               receive_done_flag,
	input  wire logic               transmit_done_flag,
	input  wire logic               reset_pin,
	output ipmc_pkg::ipmc_req_s     irq_req,
	input  wire logic               irq_ack,
	output logic                    cpu_clk_gate,
	output logic                    osc_enable,
	output logic                    ram_write_block,
	output logic                    irq
);
	import ipmc_pkg::*;

	initial begin
		if (NSRC != 5)
			$error("ipmc_ctrl serves exactly five sources");
	end

	logic [7:0] irq_enable_reg;
	logic [7:0] irq_priority_reg;
	logic [7:0] power_control_reg;
	logic [1:0] ext_sync1_r;
	logic [1:0] ext_sync2_r;
	logic [1:0] ext_prev_r;
	logic       ext0_request_flag;
	logic       ext1_request_flag;
	logic [1:0] rstp_sync_r;
	logic       rstp_prev_r;
	logic [4:0] pend;
	logic [4:0] ev_stat_r;
	logic [4:0] ev_mask_r;
	logic [1:0] act_r;
	ipmc_pwr_e  pwr_r;
	logic [1:0] win_cnt_r;
	logic       acc_wr;
	logic       en_wr;
	logic       pr_wr;
	logic       pw_wr;
	logic [2:0] sel_src;
	logic       sel_high;
	logic       sel_valid;
	logic [4:0] fwd;

	assign acc_wr = bus.wr && (pwr_r == IPMC_RUN);
	assign en_wr  = acc_wr && bus.addr == `IPMC_ADDR_ENABLE;
	assign pr_wr  = acc_wr && bus.addr == `IPMC_ADDR_PRIORITY;
	assign pw_wr  = acc_wr && bus.addr == `IPMC_ADDR_POWER;

	// first picks the lowest index: polling order is the bit order
	function automatic logic [2:0] first_set(input logic [4:0] v);
		first_set = 3'h0;
		for (int i = 4; i >= 0; i--)
			if (v[i])
				first_set = 3'(i);
	endfunction

	function automatic logic [15:0] vec_of(input logic [2:0] s);
		case (s)
			3'h0: vec_of = `IPMC_VEC_EXT0;
			3'h1: vec_of = `IPMC_VEC_TMR0;
			3'h2: vec_of = `IPMC_VEC_EXT1;
			3'h3: vec_of = `IPMC_VEC_TMR1;
			3'h4: vec_of = `IPMC_VEC_SERIAL;
			default: vec_of = `IPMC_VEC_RESET;
		endcase
	endfunction

	// pins cross from outside: two flops before any logic
	always_ff @(posedge clk) begin
		ext_sync1_r <= {ext_request_pin_1, ext_request_pin_0};
		ext_sync2_r <= ext_sync1_r;
		rstp_sync_r <= {rstp_sync_r[0], reset_pin};
		rstp_prev_r <= rstp_sync_r[1];
	end

	// falling edge of an external pin latches its request flag
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_prev_r        <= 2'h3;
			ext0_request_flag <= 1'b0;
			ext1_request_flag <= 1'b0;
		end else begin
			ext_prev_r <= ext_sync2_r;
			if (ext_prev_r[0] && !ext_sync2_r[0])
				ext0_request_flag <= 1'b1;
			else if (irq_ack && irq_req.src == 3'h0)
				ext0_request_flag <= 1'b0;
			if (ext_prev_r[1] && !ext_sync2_r[1])
				ext1_request_flag <= 1'b1;
			else if (irq_ack && irq_req.src == 3'h2)
				ext1_request_flag <= 1'b0;
		end
	end

	// serial request is either done flag
	assign pend = {receive_done_flag | transmit_done_flag,
		timer1_overflow_flag, ext1_request_flag,
		timer0_overflow_flag, ext0_request_flag};

	// registers: writes blocked in idle and power-down, held contents
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_enable_reg   <= `IPMC_ENABLE_RST;
			irq_priority_reg <= `IPMC_PRIORITY_RST;
		end else begin
			if (en_wr)
				irq_enable_reg <= bus.wdata;
			if (pr_wr)
				irq_priority_reg <= bus.wdata;
		end
	end

	// forwarded only with own and global enable; else stays pending
	assign fwd = pend & irq_enable_reg[4:0]
		& {5{irq_enable_reg[`IPMC_EN_GLOBAL_BIT]}};

	// level first, then polling order
	always_comb begin
		logic [4:0] hi;
		logic [4:0] lo;
		hi        = fwd & irq_priority_reg[4:0];
		lo        = fwd & ~irq_priority_reg[4:0];
		sel_high  = |hi;
		sel_src   = sel_high ? first_set(hi) : first_set(lo);
		// nothing preempts high; only high preempts low
		// oscillator stopped: nothing may be offered to the cpu
		if (pwr_r == IPMC_PDWN)
			sel_valid = 1'b0;
		else if (act_r[1])
			sel_valid = 1'b0;
		else if (act_r[0])
			sel_valid = sel_high;
		else
			sel_valid = |fwd;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_req <= '0;
		end else begin
			irq_req.valid  <= sel_valid && !irq_ack;
			irq_req.src    <= sel_src;
			irq_req.high   <= sel_high;
			irq_req.vector <= sel_valid ? vec_of(sel_src) : `IPMC_VEC_RESET;
		end
	end

	// active levels: set on acknowledge, cleared on return from service
	always_ff @(posedge clk) begin
		if (rst) begin
			act_r <= 2'h0;
		end else if (irq_ack && irq_req.valid) begin
			act_r[irq_req.high] <= 1'b1;
		end else if (acc_wr && bus.addr == `IPMC_ADDR_RETI) begin
			if (act_r[1])
				act_r[1] <= 1'b0;
			else
				act_r[0] <= 1'b0;
		end
	end

	// power mode machine
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_r             <= IPMC_RUN;
			power_control_reg <= `IPMC_POWER_RST;
		end else begin
			case (pwr_r)
				IPMC_RUN: begin
					if (pw_wr) begin
						power_control_reg <= bus.wdata;
						if (bus.wdata[`IPMC_PWR_PD_BIT])
							pwr_r <= IPMC_PDWN;
						else if (bus.wdata[`IPMC_PWR_IDLE_BIT])
							pwr_r <= IPMC_IDLE;
					end
				end
				IPMC_IDLE: begin
					if (|fwd) begin
						pwr_r <= IPMC_RUN;
						power_control_reg[`IPMC_PWR_IDLE_BIT] <= 1'b0;
					end
				end
				// interrupts ignored; only rst leaves
				IPMC_PDWN: pwr_r <= IPMC_PDWN;
				default: pwr_r <= IPMC_RUN;
			endcase
		end
	end

	// reset pin seen during idle: cpu runs briefly, ram writes blocked
	// rising edge only: a held pin must not keep the cpu running
	always_ff @(posedge clk) begin
		if (rst) begin
			win_cnt_r <= 2'h0;
		end else if (pwr_r == IPMC_IDLE && rstp_sync_r[1]
			&& !rstp_prev_r) begin
			win_cnt_r <= 2'(`IPMC_RST_WIN_MC);
		end else if (mc_en && win_cnt_r != 2'h0) begin
			win_cnt_r <= win_cnt_r - 2'h1;
		end
	end

	assign ram_write_block = win_cnt_r != 2'h0;
	assign cpu_clk_gate = (pwr_r == IPMC_RUN) || ram_write_block;
	assign osc_enable   = pwr_r != IPMC_PDWN;

	// event status: set wins over write-one clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ev_stat_r <= 5'h00;
			ev_mask_r <= 5'h00;
		end else begin
			ev_stat_r <= (ev_stat_r & ~((bus.wr && bus.addr ==
				`IPMC_ADDR_IRQ_STAT) ? bus.wdata[4:0] : 5'h00)) | pend;
			if (bus.wr && bus.addr == `IPMC_ADDR_IRQ_MASK)
				ev_mask_r <= bus.wdata[4:0];
		end
	end

	assign irq = |(ev_stat_r & ev_mask_r);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`IPMC_ADDR_ENABLE:   rdata <= irq_enable_reg;
				`IPMC_ADDR_PRIORITY: rdata <= irq_priority_reg;
				`IPMC_ADDR_POWER:    rdata <= power_control_reg;
				`IPMC_ADDR_FLAGS:    rdata <= {3'h0, pend};
				`IPMC_ADDR_IRQ_STAT: rdata <= {3'h0, ev_stat_r};
				`IPMC_ADDR_IRQ_MASK: rdata <= {3'h0, ev_mask_r};
				`IPMC_ADDR_STATUS:   rdata <= {4'h0, act_r, pwr_r};
				default:             rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	property p_high_blocks;
		@(posedge clk) disable iff (rst)
		act_r[1] |=> !irq_req.valid;
	endproperty
	a_high_blocks: assert property (p_high_blocks)
		else $error("request offered during high-level service");

	property p_low_only_high;
		@(posedge clk) disable iff (rst)
		(act_r[0] && !act_r[1] && !irq_ack) ##1 irq_req.valid
			|-> irq_req.high;
	endproperty
	a_low_only_high: assert property (p_low_only_high)
		else $error("low request preempted low service");

	property p_level_first;
		@(posedge clk) disable iff (rst)
		(|(fwd & irq_priority_reg[4:0]) && sel_valid && !irq_ack)
			|=> irq_req.high;
	endproperty
	a_level_first: assert property (p_level_first)
		else $error("low level chosen over high");

	property p_poll_order;
		@(posedge clk) disable iff (rst)
		(fwd[0] && irq_priority_reg[0] && sel_valid && !irq_ack)
			|=> irq_req.src == 3'h0;
	endproperty
	a_poll_order: assert property (p_poll_order)
		else $error("polling order broken");

	property p_vector;
		@(posedge clk) disable iff (rst)
		irq_req.valid |-> irq_req.vector == vec_of(irq_req.src);
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector does not match source");

	property p_idle_wake;
		@(posedge clk) disable iff (rst)
		(pwr_r == IPMC_IDLE && |fwd) |=> pwr_r == IPMC_RUN;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle not left on enabled request");

	property p_pd_stays;
		@(posedge clk) disable iff (rst)
		pwr_r == IPMC_PDWN |=> (pwr_r == IPMC_PDWN && !osc_enable);
	endproperty
	a_pd_stays: assert property (p_pd_stays)
		else $error("power-down left without reset");

	property p_pd_no_req;
		@(posedge clk) disable iff (rst)
		pwr_r == IPMC_PDWN |=> !irq_req.valid;
	endproperty
	a_pd_no_req: assert property (p_pd_no_req)
		else $error("request offered in power-down");

	property p_gate;
		@(posedge clk) disable iff (rst)
		(pw_wr && bus.wdata[1:0] == 2'h1) |=> !cpu_clk_gate;
	endproperty
	a_gate: assert property (p_gate)
		else $error("idle write did not gate cpu");

	property p_forward;
		@(posedge clk) disable iff (rst)
		!irq_enable_reg[`IPMC_EN_GLOBAL_BIT] |=> !irq_req.valid;
	endproperty
	a_forward: assert property (p_forward)
		else $error("request forwarded with global enable off");
endmodule

/* File: dv/ipmc_cpu_model.sv */
`timescale 1ns/1ps
module ipmc_cpu_model (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                slow,
	input  wire logic [5:0]          raise,
	input  wire ipmc_pkg::ipmc_req_s irq_req,
	output logic                     irq_ack,
	output logic                     ext_request_pin_0,
	output logic                     ext_request_pin_1,
	output logic                     timer0_overflow_flag,
	output logic                     timer1_overflow_flag,
	output logic                     receive_done_flag,
	output logic                     transmit_done_flag
);
	import ipmc_pkg::*;
	logic [2:0] lo0;
	logic [2:0] lo1;
	logic [2:0] dly;
	// pins idle high; low for a few cycles so the synchroniser sees the fall
	assign ext_request_pin_0 = (lo0 == 3'h0);
	assign ext_request_pin_1 = (lo1 == 3'h0);
	always_ff @(posedge clk) begin
		if (rst) begin
			{timer0_overflow_flag, timer1_overflow_flag} <= 2'h0;
			{receive_done_flag, transmit_done_flag} <= 2'h0;
			lo0 <= 3'h0;
			lo1 <= 3'h0;
			irq_ack <= 1'b0;
			dly <= 3'h0;
		end else begin
			irq_ack <= 1'b0;
			lo0 <= raise[0] ? 3'h4 : ((lo0 != 3'h0) ? lo0 - 3'h1 : 3'h0);
			lo1 <= raise[2] ? 3'h4 : ((lo1 != 3'h0) ? lo1 - 3'h1 : 3'h0);
			if (raise[1]) timer0_overflow_flag <= 1'b1;
			if (raise[3]) timer1_overflow_flag <= 1'b1;
			if (raise[4]) receive_done_flag <= 1'b1;
			if (raise[5]) transmit_done_flag <= 1'b1;
			// level flags stay up until their own service is taken
			if (irq_req.valid && !irq_ack) begin
				if (dly >= (slow ? 3'h3 : 3'h0)) begin
					irq_ack <= 1'b1;
					dly <= 3'h0;
					case (irq_req.src)
						3'h1: timer0_overflow_flag <= 1'b0;
						3'h3: timer1_overflow_flag <= 1'b0;
						3'h4: {receive_done_flag, transmit_done_flag} <= 2'h0;
						default: ;
					endcase
				end else dly <= dly + 3'h1;
			end
		end
	end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
	import ipmc_pkg::*;
	logic       clk, rst, mc_en, ack, slow, rpin, p0, p1, t0, t1, rx, tx;
	logic       gate, osc, blk, irq;
	ipmc_bus_s  bus;
	ipmc_req_s  irq_req;
	logic [7:0] rdata, d;
	logic [5:0] raise;
	logic [4:0] pend, prio;
	logic [2:0] s;
	int         err_count, n_tests, cyc, k;
	ipmc_ctrl u_dut (.clk(clk), .rst(rst), .mc_en(mc_en), .bus(bus),
		.rdata(rdata), .ext_request_pin_0(p0), .ext_request_pin_1(p1),
		.timer0_overflow_flag(t0), .timer1_overflow_flag(t1),
		.receive_done_flag(rx), .transmit_done_flag(tx), .reset_pin(rpin),
		.irq_req(irq_req), .irq_ack(ack), .cpu_clk_gate(gate),
		.osc_enable(osc), .ram_write_block(blk), .irq(irq));
	ipmc_cpu_model u_cpu (.clk(clk), .rst(rst), .slow(slow), .raise(raise),
		.irq_req(irq_req), .irq_ack(ack), .ext_request_pin_0(p0),
		.ext_request_pin_1(p1), .timer0_overflow_flag(t0),
		.timer1_overflow_flag(t1), .receive_done_flag(rx),
		.transmit_done_flag(tx));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// machine cycle shortened to 4 clocks to keep the run brief
	always @(posedge clk) begin
		cyc <= cyc + 1;
		mc_en <= (cyc % 4 == 3);
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] v);
		@(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 d = rdata;
	endtask
	task automatic up(logic [5:0] r);
		@(posedge clk) raise <= r;
		@(posedge clk) raise <= '0;
	endtask
	task automatic do_reset();
		@(posedge clk) rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rpin <= 1'b0;
		tick(2);
	endtask
	task automatic serve(logic [2:0] se, logic hi, logic ret);
		k = 0;
		while (irq_req.valid !== 1'b1 && k < 60) begin
			tick(1);
			k++;
		end
		chk("source", irq_req.src, se);
		chk("vector", irq_req.vector, 16'h0003 + 16'(se) * 16'h8);
		chk("level", irq_req.high, hi);
		while (irq_req.valid === 1'b1 && k < 120) begin
			tick(1);
			k++;
		end
		if (ret) wr(4'h7, 8'h00);
	endtask
	function automatic logic [2:0] winner(logic [4:0] p, logic [4:0] lv);
		logic [4:0] m;
		winner = 3'h0;
		m = ((p & lv) != 5'h00) ? (p & lv) : p;
		for (int i = 4; i >= 0; i--) if (m[i]) winner = 3'(i);
	endfunction
	initial begin
		{rst, slow, rpin, bus, raise} = '0;
		rst = 1'b1;
		void'($urandom(68));
		do_reset();
		for (int a = 0; a < 3; a++) begin
			rd(4'(a));
			chk("reset value", d, 8'h00);
		end
		rd(4'h8);
		chk("unmapped", d, 8'h00);
		repeat (12) begin
			pend = 5'($urandom_range(1, 31));
			prio = 5'($urandom());
			slow = 1'($urandom());
			k = $urandom();
			wr(4'h0, 8'h1F);
			wr(4'h1, {3'h0, prio});
			up({pend[4] & k[0], pend[4] & ~k[0], pend[3:0]});
			tick(20);
			chk("global off", irq_req.valid, 1'b0);
			rd(4'h1);
			chk("priority", d, {3'h0, prio});
			wr(4'h0, 8'h9F);
			while (pend != 5'h00) begin
				s = winner(pend, prio);
				serve(s, prio[s], 1'b1);
				pend[s] = 1'b0;
			end
		end
		wr(4'h1, 8'h02);
		up(6'h08);
		serve(3'h3, 1'b0, 1'b0);
		up(6'h10);
		tick(20);
		chk("low over low", irq_req.valid, 1'b0);
		up(6'h02);
		serve(3'h1, 1'b1, 1'b0);
		// ext0 made high so only the high-service block can hold it off
		wr(4'h1, 8'h03);
		up(6'h01);
		tick(20);
		chk("over high", irq_req.valid, 1'b0);
		wr(4'h7, 8'h00);
		serve(3'h0, 1'b1, 1'b1);
		tick(20);
		chk("low still busy", irq_req.valid, 1'b0);
		wr(4'h7, 8'h00);
		serve(3'h4, 1'b0, 1'b1);
		wr(4'h0, 8'h00);
		wr(4'h5, 8'h1F);
		wr(4'h4, 8'h1F);
		up(6'h01);
		tick(8);
		chk("irq raised", irq, 1'b1);
		rd(4'h4);
		chk("event bit", d[0], 1'b1);
		wr(4'h5, 8'h00);
		tick(1);
		chk("irq masked", irq, 1'b0);
		wr(4'h5, 8'h1F);
		// pending ext0 re-sets its bit each cycle; serve it before the clear
		wr(4'h0, 8'h81);
		serve(3'h0, 1'b1, 1'b1);
		wr(4'h4, 8'h01);
		tick(1);
		chk("irq cleared", irq, 1'b0);
		// no port write follows the idle request
		wr(4'h0, 8'h82);
		wr(4'h2, 8'h01);
		tick(2);
		chk("idle gate", gate, 1'b0);
		rd(4'h0);
		chk("held in idle", d, 8'h82);
		up(6'h08);
		tick(20);
		chk("disabled wake", gate, 1'b0);
		up(6'h02);
		serve(3'h1, 1'b1, 1'b1);
		chk("wake", gate, 1'b1);
		wr(4'h2, 8'h01);
		tick(2);
		@(posedge clk) rpin <= 1'b1;
		k = 0;
		repeat (40) begin
			tick(1);
			if (blk === 1'b1) k++;
		end
		chk("ram block", 16'(k > 4 && k < 10), 16'h1);
		do_reset();
		wr(4'h0, 8'h82);
		wr(4'h1, 8'h05);
		wr(4'h2, 8'h02);
		tick(2);
		chk("osc stop", osc, 1'b0);
		up(6'h02);
		tick(20);
		chk("pd stays", osc, 1'b0);
		chk("pd no irq", irq_req.valid, 1'b0);
		do_reset();
		chk("osc restart", osc, 1'b1);
		for (int a = 0; a < 3; a++) begin
			rd(4'(a));
			chk("pd reset value", d, 8'h00);
		end
		stop_test();
	end
endmodule
